// ===== aps_regs.vh
// Constants for the converter output block
`ifndef APS_REGS_VH
`define APS_REGS_VH
`define APS_WORD_W        15
`define APS_LATENCY       3
`define APS_CLK_PERIOD_PS 8000
`define APS_DAV_DELAY_PS  6500
`define APS_BUF_DEPTH     2
`define APS_MAX_CODE      15'h3FFF
`define APS_MIN_CODE      15'h4000
`endif

// ===== aps_skid_buf.v
// Two-entry valid/ready buffer carrying result words
`timescale 1ns/1ns
module aps_skid_buf #(
  parameter W = 16
) (
  input  wire         core_clk_in,
  input  wire         rst_n_in,
  input  wire         in_valid_in,
  output wire         in_ready_out,
  input  wire [W-1:0] in_data_in,
  output wire         out_valid_out,
  input  wire         out_ready_in,
  output wire [W-1:0] out_data_out
);
  reg [W-1:0] mem_q [0:1];
  reg         wr_q;
  reg         rd_q;
  reg [1:0]   cnt_q;
  wire        push;
  wire        pop;
  assign in_ready_out  = (cnt_q != 2'h2);
  assign out_valid_out = (cnt_q != 2'h0);
  assign out_data_out  = mem_q[rd_q];
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      cnt_q    <= 2'h0;
      mem_q[0] <= {W{1'b0}};
      mem_q[1] <= {W{1'b0}};
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data_in;
        wr_q        <= ~wr_q;
      end
      if (pop)
        rd_q <= ~rd_q;
      if (push && !pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule // aps_skid_buf

// ===== aps_sample_out.v
// Converter output stage: sampling, pipeline, parallel word, overrange, valid strobe
// Notes on behaviour
// - Sample the input at each rising edge of the differential conversion clock.
// - Deliver each result as a 15-bit two's-complement parallel word.
// - Output bit 0 is LSB, bit 14 MSB; capture assembles in that order.
// - Overrange flag high beyond full scale, low inside full scale.
// - Valid strobe rises about 6.5ns after the conversion clock falling edge; the code raises it one core cycle after the detected fall loads the word.
// - Word appears three clock cycles after sampling, valid at strobe rise.
// - Overrange flag has exactly the data timing, per sample.
`timescale 1ns/1ns
`include "aps_regs.vh"
module aps_sample_out #(
  parameter W   = `APS_WORD_W,
  parameter LAT = `APS_LATENCY
) (
  input  wire         core_clk_in,
  input  wire         reset_n_in,
  input  wire         conv_clock_pos_in,
  input  wire         conv_clock_neg_in,
  input  wire [W:0]   analog_in_pos_in,
  input  wire [W:0]   analog_in_neg_in,
  output reg  [W-1:0] sample_word_out,
  output reg          overrange_flag_out,
  output reg          data_valid_strobe_out,
  output reg          buf_overflow_out
);
  // Strobe delay in core cycles, rounded down, at least one
  localparam integer DAV_RAW = `APS_DAV_DELAY_PS / `APS_CLK_PERIOD_PS;
  localparam integer DAV_CYC = (DAV_RAW < 1) ? 1 : DAV_RAW;
  // Strobe sequencer states
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_HIGH = 2'h2;

  reg         rst_s1_q;
  reg         rst_q;
  reg         ckp_s1_q;
  reg         ckp_s2_q;
  reg         ckn_s1_q;
  reg         ckn_s2_q;
  reg         clk_lvl_q;
  reg [W:0]   ainp_s1_q;
  reg [W:0]   ainp_s2_q;
  reg [W:0]   ainn_s1_q;
  reg [W:0]   ainn_s2_q;
  reg [W:0]   pipe_q [0:LAT-1];
  reg [3:0]   dav_cnt_q;
  reg [3:0]   dav_cnt_d;
  reg [1:0]   st_q;
  reg [1:0]   st_d;
  reg [W-1:0] word_d;
  reg         flag_d;
  reg         dav_d;
  reg         ovf_d;
  integer     i;
  wire        clk_diff;
  wire        rise;
  wire        fall;
  wire [W+1:0] diff;
  wire [W:0]  conv;
  wire        in_ready;
  wire        out_valid;
  wire [W:0]  out_data;

  // Saturate the differential input to the word range and flag the clip
  function [W:0] aps_convert;
    input [W+1:0] d;
    begin
      if ($signed(d) > $signed({3'h0, `APS_MAX_CODE}))
        aps_convert = {1'b1, `APS_MAX_CODE};
      else if ($signed(d) < $signed({3'h7, `APS_MIN_CODE}))
        aps_convert = {1'b1, `APS_MIN_CODE};
      else
        aps_convert = {1'b0, d[W-1:0]};
    end
  endfunction

  // Edge of a synchronised level against its delayed copy; dir high means rising
  function aps_edge;
    input lvl;
    input prv;
    input dir;
    begin
      aps_edge = dir ? (lvl & ~prv) : (~lvl & prv);
    end
  endfunction

  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_s1_q <= 1'b0;
      rst_q    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_q    <= rst_s1_q;
    end
  end

  // Pins from outside the domain pass two flops before use
  always @(posedge core_clk_in or negedge rst_q) begin
    if (!rst_q) begin
      ckp_s1_q <= 1'b0;
      ckp_s2_q <= 1'b0;
      ckn_s1_q <= 1'b1;
      ckn_s2_q <= 1'b1;
    end else begin
      ckp_s1_q <= conv_clock_pos_in;
      ckp_s2_q <= ckp_s1_q;
      ckn_s1_q <= conv_clock_neg_in;
      ckn_s2_q <= ckn_s1_q;
    end
  end

  // Legs must hold steady around a rise; the word is synced bit by bit
  always @(posedge core_clk_in or negedge rst_q) begin
    if (!rst_q) begin
      ainp_s1_q <= {(W+1){1'b0}};
      ainp_s2_q <= {(W+1){1'b0}};
      ainn_s1_q <= {(W+1){1'b0}};
      ainn_s2_q <= {(W+1){1'b0}};
    end else begin
      ainp_s1_q <= analog_in_pos_in;
      ainp_s2_q <= ainp_s1_q;
      ainn_s1_q <= analog_in_neg_in;
      ainn_s2_q <= ainn_s1_q;
    end
  end

  // Differential clock: positive above negative means high
  assign clk_diff = ckp_s2_q & ~ckn_s2_q;
  assign rise     = aps_edge(clk_diff, clk_lvl_q, 1'b1);
  assign fall     = aps_edge(clk_diff, clk_lvl_q, 1'b0);
  assign diff     = {ainp_s2_q[W], ainp_s2_q} - {ainn_s2_q[W], ainn_s2_q};
  assign conv     = aps_convert(diff);

  always @(posedge core_clk_in or negedge rst_q) begin
    if (!rst_q) begin
      clk_lvl_q <= 1'b0;
      for (i = 0; i < LAT; i = i + 1)
        pipe_q[i] <= {(W+1){1'b0}};
    end else begin
      clk_lvl_q <= clk_diff;
      if (rise) begin
        pipe_q[0] <= conv;
        for (i = 1; i < LAT; i = i + 1)
          pipe_q[i] <= pipe_q[i-1];
      end
    end
  end

  // Buffer decouples the pipeline from the output register; popped once per clock
  aps_skid_buf #(
    .W (W+1)
  ) u_buf (
    .core_clk_in   (core_clk_in),
    .rst_n_in      (rst_q),
    .in_valid_in   (rise),
    .in_ready_out  (in_ready),
    .in_data_in    (pipe_q[LAT-1]),
    .out_valid_out (out_valid),
    .out_ready_in  (fall),
    .out_data_out  (out_data)
  );

  // Next output state: load at a detected fall, count the delay, drop at the next rise
  always @* begin
    st_d      = st_q;
    dav_cnt_d = dav_cnt_q;
    word_d    = sample_word_out;
    flag_d    = overrange_flag_out;
    dav_d     = data_valid_strobe_out;
    // Sticky: a word pushed into a full buffer is lost
    ovf_d     = buf_overflow_out | (rise & ~in_ready);
    if (fall && out_valid) begin
      word_d    = out_data[W-1:0];
      flag_d    = out_data[W];
      dav_d     = 1'b0;
      dav_cnt_d = 4'h1;
      st_d      = ST_WAIT;
    end else begin
      case (st_q)
        ST_IDLE: begin
          dav_d = 1'b0;
        end
        ST_WAIT: begin
          if (dav_cnt_q >= DAV_CYC[3:0]) begin
            dav_d = 1'b1;
            st_d  = ST_HIGH;
          end else begin
            dav_cnt_d = dav_cnt_q + 4'h1;
          end
        end
        ST_HIGH: begin
          if (rise) begin
            dav_d = 1'b0;
            st_d  = ST_IDLE;
          end
        end
        default: begin
          dav_d = 1'b0;
          st_d  = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge core_clk_in or negedge rst_q) begin
    if (!rst_q) begin
      st_q                  <= ST_IDLE;
      dav_cnt_q             <= 4'h0;
      sample_word_out       <= {W{1'b0}};
      overrange_flag_out    <= 1'b0;
      data_valid_strobe_out <= 1'b0;
      buf_overflow_out      <= 1'b0;
    end else begin
      st_q                  <= st_d;
      dav_cnt_q             <= dav_cnt_d;
      sample_word_out       <= word_d;
      overrange_flag_out    <= flag_d;
      data_valid_strobe_out <= dav_d;
      buf_overflow_out      <= ovf_d;
    end
  end
endmodule // aps_sample_out

// ===== aps_props.sv
// Timing checks on the converter output stage
`timescale 1ns/1ns
`include "aps_regs.vh"
module aps_props #(
  parameter W = 15
) (
  input wire         core_clk_in,
  input wire         reset_n_in,
  input wire         conv_clock_pos_in,
  input wire         conv_clock_neg_in,
  input wire [W:0]   analog_in_pos_in,
  input wire [W:0]   analog_in_neg_in,
  input wire [W-1:0] sample_word_out,
  input wire         overrange_flag_out,
  input wire         data_valid_strobe_out,
  input wire         buf_overflow_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  wire       dif = conv_clock_pos_in & ~conv_clock_neg_in;
  wire       data_valid_strobe = data_valid_strobe_out;
  wire [W:0] res = {overrange_flag_out, sample_word_out};
  sequence s_fall; $fell(dif); endsequence
  sequence s_up; ##[2:7] $rose(data_valid_strobe); endsequence
  a_dav_after_fall: assert property (s_fall |-> s_up)
    else $error("no strobe after fall");
  a_dav_one_edge: assert property ($rose(data_valid_strobe) |=> (!$rose(data_valid_strobe))[*8])
    else $error("second strobe edge");
  a_dav_drop_rise: assert property ($rose(dif) |-> ##[1:5] !data_valid_strobe)
    else $error("strobe not low after rise");
  a_dav_high_hold: assert property ($rose(data_valid_strobe) |=> data_valid_strobe[*2])
    else $error("strobe too short");
  a_word_holds: assert property (data_valid_strobe |-> $stable(res))
    else $error("word moved under strobe");
  a_change_clock_low: assert property ($changed(res) |-> !dif)
    else $error("word moved while clock high");
  a_flag_full_scale: assert property (overrange_flag_out |->
    (sample_word_out == `APS_MAX_CODE || sample_word_out == `APS_MIN_CODE))
    else $error("flag without full scale code");
  a_flag_word_time: assert property ($changed(overrange_flag_out) |-> !$past(data_valid_strobe) && !dif)
    else $error("flag off word timing");
endmodule // aps_props
bind aps_sample_out aps_props #(.W(W)) aps_props_inst (.core_clk_in, .reset_n_in,
  .conv_clock_pos_in, .conv_clock_neg_in, .analog_in_pos_in, .analog_in_neg_in,
  .sample_word_out, .overrange_flag_out, .data_valid_strobe_out, .buf_overflow_out);

// ===== aps_capture_model.sv
// Capture register clocked by the valid strobe
`timescale 1ns/1ns
module aps_capture_model (
  input  wire        strobe_in,
  input  wire [14:0] word_in,
  input  wire        flag_in,
  output reg  [14:0] cap_word_out = 15'h0000,
  output reg         cap_flag_out = 1'b0
);
  always @(posedge strobe_in) begin
    cap_word_out <= word_in;
    cap_flag_out <= flag_in;
  end
endmodule // aps_capture_model

// ===== aps_sample_out_bench.sv
// Self-checking bench for the converter output stage
`timescale 1ns/1ns
module aps_sample_out_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cv = 1'b0;
  logic        run = 1'b0;
  logic [15:0] ap = 16'h0000;
  logic [15:0] an = 16'h0000;
  logic [47:0] rows [0:8];
  wire  [14:0] word, cw;
  wire         flag, data_valid_strobe, ovf, cf;
  int          err_total = 0;
  int          samples_checked = 0;
  int          cv_cnt = 0;
  always #4 clk = ~clk;
  // Conversion clock from the core edge: five cycles per half period gives 80 ns
  always @(posedge clk) begin
    if (run) begin
      cv_cnt <= (cv_cnt == 4) ? 0 : cv_cnt + 1;
      if (cv_cnt == 4) begin
        cv <= ~cv;
      end
    end
  end
  aps_sample_out aps_sample_out_inst (.core_clk_in(clk), .reset_n_in(rst_n),
    .conv_clock_pos_in(cv), .conv_clock_neg_in(~cv), .analog_in_pos_in(ap),
    .analog_in_neg_in(an), .sample_word_out(word), .overrange_flag_out(flag),
    .data_valid_strobe_out(data_valid_strobe), .buf_overflow_out(ovf));
  aps_capture_model aps_capture_model_inst (.strobe_in(data_valid_strobe), .word_in(word),
    .flag_in(flag), .cap_word_out(cw), .cap_flag_out(cf));
  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    // Rows: plus leg, minus leg, then word and flag
    rows = '{48'h0000_0000_0000, 48'h0001_0000_0002, 48'h3FFF_0000_7FFE,
      48'h4000_0000_7FFF, 48'h0000_4000_8000, 48'h0000_4001_8001,
      48'h0005_0007_FFFC, 48'h7FFF_8000_7FFF, 48'h0000_0001_FFFE};
    repeat (10) @(posedge clk);
    check({flag | data_valid_strobe | ovf, word}, 16'h0000);
    $display("reset test done");
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    run <= 1'b1;
    // Result of the row set at one fall is held by capture five falls later
    for (int n = 0; n < 14; n++) begin
      @(negedge cv);
      if (n >= 5) check({cw, cf}, rows[n - 5][15:0]);
      ap <= (n < 9) ? rows[n][47:32] : 16'h0000;
      an <= (n < 9) ? rows[n][31:16] : 16'h0000;
      $display("row %0d done", n);
    end
    // Mid-run reset on a rising edge, released one period later on the next rise
    @(posedge cv);
    rst_n <= 1'b0;
    ap <= 16'h0003;
    @(posedge clk);
    check({flag | data_valid_strobe | ovf, word}, 16'h0000);
    repeat (9) @(posedge clk);
    rst_n <= 1'b1;
    // Three fill words of zero first, then the sample taken at the release rise
    for (int k = 0; k < 5; k++) begin
      @(negedge cv);
      if (k > 0) check({cw, cf}, (k == 4) ? 16'h0006 : 16'h0000);
    end
    $display("mid-run reset test done");
    check({15'h0000, ovf}, 16'h0000);
    summarize();
  end
  initial begin
    #5000;
    err_total++;
    summarize();
  end
endmodule // aps_sample_out_bench
